// [core/cell_balance_pkg.sv]
// constants and register map for the cell balancing controller
package cell_balance_pkg;
	localparam int NUM_CH = 16;
	localparam int TIMER_W = 8;
	localparam int VOLT_W = 16;
	localparam int TEMP_W = 4;
	localparam int MAX_MANUAL_CH = 8;
	// register byte offsets
	localparam logic [7:0] CTRL_OFF = 8'h00;
	localparam logic [7:0] STATUS_OFF = 8'h04;
	localparam logic [7:0] THERM_OFF = 8'h08;
	localparam logic [7:0] STOPV_OFF = 8'h0c;
	localparam logic [7:0] SWITCH_OFF = 8'h10;
	localparam logic [7:0] TIMER_BASE = 8'h40;
	// control fields
	localparam int GO_BIT = 0;
	localparam int AUTO_BIT = 1;
	localparam int ADJ_BIT = 2;
	localparam int THEN_BIT = 3;
	localparam int COUNT_LSB = 4;
	localparam int PERIOD_LSB = 8;
	// status fields
	localparam int RUN_BIT = 0;
	localparam int DONE_BIT = 1;
	localparam int INVAL_BIT = 2;
	localparam int PAUSE_BIT = 3;
	localparam int OTP_BIT = 4;
	// thermistor config fields
	localparam int THR_LSB = 0;
	localparam int COOL_LSB = 4;
	// reset values
	localparam logic [3:0] COUNT_RST = 4'hf;
	localparam logic [2:0] PERIOD_RST = 3'h0;
	// timer tick
	localparam int CLK_HZ = 25000000;
	localparam int TICK_MS = 1000;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	typedef enum logic {ST_IDLE, ST_RUN} bal_state_t;
endpackage

// [core/cell_balancing_controller.sv]
// cell balancing controller with wishbone register access
`timescale 1ns/100ps
module cell_balancing_controller
	import cell_balance_pkg::*;
#(
	parameter int TICK_CNT = TICK_CYCLES
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic die_hot_i,
	input wire logic die_cool_i,
	input wire logic [TEMP_W-1:0] therm_max_i,
	input wire logic ot_restart_i,
	input wire logic uv_restart_i,
	input wire logic [NUM_CH-1:0] cell_under_i,
	output logic [NUM_CH-1:0] balance_switch_o,
	output logic die_sense_en_o,
	output logic [VOLT_W-1:0] stop_threshold_o
);

	// bus decode and run state
	bal_state_t state_q;
	logic acc;
	logic wr;
	logic go;
	logic go_q;
	// control register fields
	logic auto_alternate_select_q;
	logic forbid_adjacent_q;
	logic thermistor_pause_enable_q;
	logic [3:0] active_channel_count_q;
	logic [2:0] alternation_period_q;
	logic run_auto_q;
	logic [2:0] run_period_q;
	// thresholds, shadow and latched copies
	logic [3:0] thr_cfg_q;
	logic [2:0] cool_cfg_q;
	logic [3:0] thr_lat_q;
	logic [2:0] cool_lat_q;
	logic [VOLT_W-1:0] stop_voltage_threshold_q;
	// per channel timers and masks
	logic [TIMER_W-1:0] timer_q [NUM_CH];
	logic [NUM_CH-1:0] nonzero;
	logic [NUM_CH-1:0] in_range;
	logic [NUM_CH-1:0] cand;
	logic [NUM_CH-1:0] sel_q;
	logic [NUM_CH-1:0] act;
	logic [NUM_CH-1:0] odd_mask;
	logic cand_bad;
	// pause and status flags
	logic die_pause_q;
	logic therm_pause_q;
	logic paused;
	logic balancing_done_flag_q;
	logic invalid_config_flag_q;
	logic overtemp_pause_flag_q;
	// tick and alternation timing
	logic [31:0] tick_cnt_q;
	logic tick;
	logic [2:0] alt_cnt_q;
	logic phase_q;
	logic [4:0] resume_lvl;
	logic ch_tick;

	assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr = acc && wb_we_i;
	assign go = wr && wb_adr_i == CTRL_OFF && wb_sel_i[0]
		&& wb_dat_i[GO_BIT];
	assign paused = die_pause_q || therm_pause_q;
	assign tick = tick_cnt_q == TICK_CNT - 1;
	assign resume_lvl = {1'b0, thr_lat_q} + {2'b00, cool_lat_q};
	assign ch_tick = state_q == ST_RUN && !paused && tick;

	// per channel decode
	generate
		for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
			logic [7:0] toff;
			assign toff = TIMER_BASE + 8'(4 * i);
			assign nonzero[i] = timer_q[i] != '0;
			assign in_range[i] = 4'(i) <= active_channel_count_q;
			assign cand[i] = nonzero[i] && in_range[i];
			assign act[i] = sel_q[i] && nonzero[i];
			assign odd_mask[i] = (i % 2) == 0;
			// timer load and countdown
			always_ff @(posedge core_clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					timer_q[i] <= '0;
				end else if (wr && wb_adr_i == toff && wb_sel_i[0]) begin
					timer_q[i] <= wb_dat_i[TIMER_W-1:0];
				end else if (ch_tick && sel_q[i] && nonzero[i]) begin
					timer_q[i] <= timer_q[i] - 1'b1;
				end
			end
		end
	endgenerate

	// manual configuration check
	always_comb begin
		int n;
		n = 0;
		cand_bad = 1'b0;
		for (int i = 0; i < NUM_CH; i++) begin
			n = n + int'(cand[i]);
		end
		if (n > MAX_MANUAL_CH) begin
			cand_bad = 1'b1;
		end
		for (int i = 1; i < NUM_CH; i++) begin
			if (forbid_adjacent_q && cand[i] && cand[i-1]) begin
				cand_bad = 1'b1;
			end
		end
		for (int i = 2; i < NUM_CH; i++) begin
			if (cand[i] && cand[i-1] && cand[i-2]) begin
				cand_bad = 1'b1;
			end
		end
	end

	// control register fields
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			auto_alternate_select_q <= 1'b0;
			forbid_adjacent_q <= 1'b0;
			thermistor_pause_enable_q <= 1'b0;
			active_channel_count_q <= COUNT_RST;
			alternation_period_q <= PERIOD_RST;
		end else if (wr && wb_adr_i == CTRL_OFF) begin
			if (wb_sel_i[0]) begin
				auto_alternate_select_q <= wb_dat_i[AUTO_BIT];
				forbid_adjacent_q <= wb_dat_i[ADJ_BIT];
				thermistor_pause_enable_q <= wb_dat_i[THEN_BIT];
				active_channel_count_q <= wb_dat_i[COUNT_LSB +: 4];
			end
			if (wb_sel_i[1]) begin
				alternation_period_q <= wb_dat_i[PERIOD_LSB +: 3];
			end
		end
	end

	// threshold shadow registers and protector latches
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			thr_cfg_q <= '0;
			cool_cfg_q <= '0;
			thr_lat_q <= '0;
			cool_lat_q <= '0;
			stop_voltage_threshold_q <= '0;
			stop_threshold_o <= '0;
		end else begin
			if (wr && wb_adr_i == THERM_OFF && wb_sel_i[0]) begin
				thr_cfg_q <= wb_dat_i[THR_LSB +: 4];
				cool_cfg_q <= wb_dat_i[COOL_LSB +: 3];
			end
			if (wr && wb_adr_i == STOPV_OFF) begin
				if (wb_sel_i[0]) begin
					stop_voltage_threshold_q[7:0] <= wb_dat_i[7:0];
				end
				if (wb_sel_i[1]) begin
					stop_voltage_threshold_q[15:8] <= wb_dat_i[15:8];
				end
			end
			if (ot_restart_i) begin
				thr_lat_q <= thr_cfg_q;
				cool_lat_q <= cool_cfg_q;
			end
			if (uv_restart_i) begin
				stop_threshold_o <= stop_voltage_threshold_q;
			end
		end
	end

	// run state, channel selection and status flags
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= ST_IDLE;
			sel_q <= '0;
			invalid_config_flag_q <= 1'b0;
			balancing_done_flag_q <= 1'b0;
		end else if (go_q) begin
			balancing_done_flag_q <= 1'b0;
			if (!auto_alternate_select_q && cand_bad) begin
				invalid_config_flag_q <= 1'b1;
				state_q <= ST_IDLE;
				sel_q <= '0;
			end else begin
				invalid_config_flag_q <= 1'b0;
				sel_q <= cand;
				state_q <= cand != '0 ? ST_RUN : ST_IDLE;
			end
		end else if (state_q == ST_RUN) begin
			if (stop_threshold_o != '0) begin
				sel_q <= sel_q & ~cell_under_i;
			end
			// running clears with no active channel
			if (act == '0) begin
				state_q <= ST_IDLE;
				balancing_done_flag_q <= 1'b1;
			end
		end
	end

	// go pulse delayed so the start sees settings written with it
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			go_q <= 1'b0;
		// validity judged on freshly written settings
		end else begin
			go_q <= go;
		end
	end

	// run settings captured at start, held through pauses
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			run_auto_q <= 1'b0;
			run_period_q <= PERIOD_RST;
		// settings frozen for the whole run
		end else if (go_q) begin
			run_auto_q <= auto_alternate_select_q;
			run_period_q <= alternation_period_q;
		end
	end

	// die temperature pause
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			die_pause_q <= 1'b0;
			die_sense_en_o <= 1'b0;
		end else begin
			die_sense_en_o <= state_q == ST_RUN || go || go_q;
			if (state_q != ST_RUN) begin
				die_pause_q <= 1'b0;
			end else if (die_hot_i) begin
				die_pause_q <= 1'b1;
			end else if (die_cool_i) begin
				die_pause_q <= 1'b0;
			end
		end
	end

	// thermistor pause
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			therm_pause_q <= 1'b0;
		end else if (state_q != ST_RUN || !thermistor_pause_enable_q) begin
			therm_pause_q <= 1'b0;
		end else if (therm_max_i > thr_lat_q) begin
			therm_pause_q <= 1'b1;
		end else if ({1'b0, therm_max_i} < resume_lvl) begin
			therm_pause_q <= 1'b0;
		end
	end

	// sticky overtemperature pause flag, set wins over clear on go
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			overtemp_pause_flag_q <= 1'b0;
		end else if (paused) begin
			overtemp_pause_flag_q <= 1'b1;
		end else if (go_q) begin
			overtemp_pause_flag_q <= 1'b0;
		end
	end

	// timer tick divider
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tick_cnt_q <= '0;
		// tick phase restarts with each run
		end else if (tick || go_q) begin
			tick_cnt_q <= '0;
		end else begin
			tick_cnt_q <= tick_cnt_q + 1'b1;
		end
	end

	// odd and even group alternation
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			alt_cnt_q <= '0;
			phase_q <= 1'b0;
		end else if (go_q) begin
			alt_cnt_q <= '0;
			phase_q <= 1'b0;
		end else if (ch_tick) begin
			if (alt_cnt_q == run_period_q) begin
				alt_cnt_q <= '0;
				phase_q <= !phase_q;
			end else begin
				alt_cnt_q <= alt_cnt_q + 1'b1;
			end
		end
	end

	// switch drive
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			balance_switch_o <= '0;
		end else if (state_q != ST_RUN || paused) begin
			balance_switch_o <= '0;
		end else if (!run_auto_q) begin
			balance_switch_o <= act;
		end else if ((act & odd_mask) == '0 || (act & ~odd_mask) == '0) begin
			balance_switch_o <= act;
		end else begin
			balance_switch_o <= act & (phase_q ? ~odd_mask : odd_mask);
		end
	end

	// wishbone answer and read data
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= acc;
			wb_dat_o <= '0;
			if (acc && !wb_we_i) begin
				unique case (wb_adr_i)
					CTRL_OFF: wb_dat_o <= {21'h0, alternation_period_q,
						active_channel_count_q, thermistor_pause_enable_q,
						forbid_adjacent_q, auto_alternate_select_q, 1'b0};
					STATUS_OFF: wb_dat_o <= {27'h0, overtemp_pause_flag_q,
						paused, invalid_config_flag_q,
						balancing_done_flag_q, state_q == ST_RUN};
					THERM_OFF: wb_dat_o <= {25'h0, cool_cfg_q, thr_cfg_q};
					STOPV_OFF: wb_dat_o <= {16'h0, stop_voltage_threshold_q};
					SWITCH_OFF: wb_dat_o <= {16'h0, balance_switch_o};
					default: begin
						if (wb_adr_i >= TIMER_BASE
							&& wb_adr_i < TIMER_BASE + 8'(4 * NUM_CH)
							&& wb_adr_i[1:0] == 2'b00) begin
							wb_dat_o <= {24'h0,
								timer_q[4'(wb_adr_i[5:2])]};
						end
					end
				endcase
			end
		end
	end

endmodule // cell_balancing_controller

// [verification/cell_balance_sva.sv]
// port-level assertions for the cell balancing controller
`timescale 1ns/100ps
module cell_balance_sva #(
	parameter int TICK_CNT = 4
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic die_hot_i,
	input wire logic uv_restart_i,
	input wire logic [15:0] cell_under_i,
	input wire logic [15:0] balance_switch_o,
	input wire logic die_sense_en_o,
	input wire logic [15:0] stop_threshold_o
);
	default clocking dc @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	logic req, go;
	logic under_on;
	// taken request and go write decode
	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign go = req & wb_we_i & (wb_adr_i == 8'h00) & wb_dat_i[0];
	assign under_on = (stop_threshold_o != '0) && |(cell_under_i & balance_switch_o);
	ack_latency_a: assert property (req |=> wb_ack_o)
		else $error("no ack one cycle after request");
	ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	ack_source_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i & wb_stb_i))
		else $error("ack without request");
	dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == '0)
		else $error("read data not zero outside ack");
	sense_go_a: assert property (go |-> ##[1:2] die_sense_en_o)
		else $error("die sensors not enabled after go");
	switch_gate_a: assert property (balance_switch_o != '0 |-> $past(die_sense_en_o))
		else $error("switch on while not balancing");
	pause_off_a: assert property (die_hot_i [*3] |=> balance_switch_o == '0)
		else $error("switch on during die pause");
	thresh_hold_a: assert property (!uv_restart_i |=> $stable(stop_threshold_o))
		else $error("stop threshold moved without restart");
	volt_stop_a: assert property (not (under_on [*4]))
		else $error("switch stays on below stop voltage");
	cover property (go);
	cover property (balance_switch_o != '0 ##1 balance_switch_o == '0);
	cover property (die_hot_i [*3]);
	cover property (uv_restart_i);
endmodule // cell_balance_sva
bind cell_balancing_controller cell_balance_sva #(.TICK_CNT(TICK_CNT)) u_sva (
	.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.die_hot_i(die_hot_i), .uv_restart_i(uv_restart_i),
	.cell_under_i(cell_under_i), .balance_switch_o(balance_switch_o),
	.die_sense_en_o(die_sense_en_o), .stop_threshold_o(stop_threshold_o));

// [verification/cell_model.sv]
// behavioural battery cells that sag while their switch is on
`timescale 1ns/100ps
module cell_model (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic [15:0] balance_switch_i,
	input wire logic [15:0] stop_threshold_i,
	output logic [15:0] cell_under_o
);
	logic [15:0] volt_q [16];
	// a switched cell loses one step per clock
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		for (int i = 0; i < 16; i++) begin
			if (!rst_n_i) begin
				volt_q[i] <= 16'h0200;
			end else if (balance_switch_i[i] && volt_q[i] != '0) begin
				volt_q[i] <= volt_q[i] - 16'h0001;
			end
		end
	end
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			cell_under_o[i] = stop_threshold_i != '0 && volt_q[i] < stop_threshold_i;
		end
	end
endmodule // cell_model

// [verification/tb.sv]
// self-checking testbench for the cell balancing controller
`timescale 1ns/100ps
module tb;
	import cell_balance_pkg::*;
	logic clk, rst_n, cyc, stb, we, ack, hot, cool, otr, uvr, sen;
	logic [7:0] adr;
	logic [31:0] dat, rdat, rd;
	logic [3:0] tmax;
	logic [15:0] under, sw, thr;
	int num_errors = 0;
	int checked = 0;
	int cycles = 0;
	cell_balancing_controller #(.TICK_CNT(4)) u_cell_balancing_controller (
		.core_clk_i(clk), .rst_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .die_hot_i(hot), .die_cool_i(cool),
		.therm_max_i(tmax), .ot_restart_i(otr), .uv_restart_i(uvr),
		.cell_under_i(under), .balance_switch_o(sw), .die_sense_en_o(sen),
		.stop_threshold_o(thr));
	cell_model u_cell_model (.core_clk_i(clk), .rst_n_i(rst_n),
		.balance_switch_i(sw), .stop_threshold_i(thr), .cell_under_o(under));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic complete_run();
		$display("checked %0d num_errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			complete_run();
		end
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one classic cycle, held until ack is sampled
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rdreg(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, '0);
		check(rd, exp);
	endtask
	task automatic set_timers(input logic [15:0] m, input logic [7:0] v);
		for (int i = 0; i < 16; i++) bus(1'b1, TIMER_BASE + 8'(i * 4), m[i] ? v : 8'h00);
	endtask
	task automatic stop_run();
		set_timers('0, '0);
		bus(1'b1, CTRL_OFF, 32'h000000f1);
	endtask
	task automatic t_reset();
		rdreg(CTRL_OFF, 32'h000000f0);
		rdreg(STATUS_OFF, '0);
		bus(1'b1, 8'h80, 32'hffffffff);
		rdreg(8'h80, '0);
		set_timers(16'h0001, 8'h10);
		rdreg(TIMER_BASE, 32'h00000010);
		rdreg(SWITCH_OFF, '0);
		check(sen, '0);
		$display("reset test done");
	endtask
	task automatic t_manual();
		set_timers(16'h0005, 8'h20);
		bus(1'b1, TIMER_BASE, 32'h00000004);
		bus(1'b1, CTRL_OFF, 32'h000000f1);
		rdreg(SWITCH_OFF, 32'h00000005);
		rdreg(STATUS_OFF, 32'h00000001);
		check(sen, 32'h00000001);
		repeat (40) @(posedge clk);
		rdreg(SWITCH_OFF, 32'h00000004);
		bus(1'b1, TIMER_BASE + 8'h08, '0);
		repeat (12) @(posedge clk);
		rdreg(STATUS_OFF, 32'h00000002);
		set_timers(16'h0005, 8'h20);
		bus(1'b1, CTRL_OFF, 32'h00000001);
		rdreg(SWITCH_OFF, 32'h00000001);
		stop_run();
		$display("manual test done");
	endtask
	task automatic t_invalid();
		logic [15:0] m [4] = '{16'h0007, 16'h0003, 16'h16db, 16'h06db};
		logic [31:0] c [4] = '{32'hf1, 32'hf5, 32'hf1, 32'hf1};
		for (int k = 0; k < 4; k++) begin
			set_timers(m[k], 8'h20);
			bus(1'b1, CTRL_OFF, c[k]);
			rdreg(STATUS_OFF, k == 3 ? 32'h1 : 32'h4);
			rdreg(SWITCH_OFF, k == 3 ? 32'(m[k]) : '0);
		end
		stop_run();
		$display("invalid test done");
	endtask
	task automatic t_auto();
		int a, b, e;
		for (int k = 0; k < 2; k++) begin
			a = 0;
			b = 0;
			e = 0;
			set_timers(k == 0 ? 16'h0003 : 16'h0005, 8'hff);
			bus(1'b1, CTRL_OFF, 32'h000000f3);
			repeat (32) begin
				@(posedge clk);
				a += (sw === 16'h0001);
				b += (sw === 16'h0002);
				e += (sw === 16'h0005);
			end
			if (k == 0) check(a > 0 && b > 0, 1);
			else check(e, 32);
			stop_run();
		end
		$display("auto test done");
	endtask
	task automatic t_pause();
		// thresholds, protector restart, then enable with go
		bus(1'b1, THERM_OFF, 32'h00000025);
		otr <= 1'b1;
		@(posedge clk);
		otr <= 1'b0;
		set_timers(16'h0001, 8'h40);
		bus(1'b1, CTRL_OFF, 32'h000000f9);
		hot <= 1'b1;
		cool <= 1'b0;
		repeat (4) @(posedge clk);
		rdreg(SWITCH_OFF, '0);
		rdreg(STATUS_OFF, 32'h00000019);
		hot <= 1'b0;
		cool <= 1'b1;
		repeat (3) @(posedge clk);
		rdreg(SWITCH_OFF, 32'h00000001);
		bus(1'b1, THERM_OFF, 32'h00000029);
		tmax <= 4'h8;
		repeat (4) @(posedge clk);
		rdreg(STATUS_OFF, 32'h00000019);
		tmax <= 4'h6;
		repeat (3) @(posedge clk);
		rdreg(SWITCH_OFF, '0);
		tmax <= 4'h4;
		repeat (3) @(posedge clk);
		rdreg(SWITCH_OFF, 32'h00000001);
		rdreg(STATUS_OFF, 32'h00000011);
		stop_run();
		$display("pause test done");
	endtask
	task automatic t_volt();
		bus(1'b1, STOPV_OFF, 32'h000001f0);
		check(thr, '0);
		uvr <= 1'b1;
		@(posedge clk);
		uvr <= 1'b0;
		@(posedge clk);
		check(thr, 32'h000001f0);
		set_timers(16'h0010, 8'hff);
		bus(1'b1, CTRL_OFF, 32'h000000f1);
		repeat (60) @(posedge clk);
		rdreg(STATUS_OFF, 32'h00000002);
		$display("voltage test done");
	endtask
	initial begin
		rst_n = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = '0;
		dat = '0;
		hot = 1'b0;
		cool = 1'b1;
		tmax = 4'h0;
		otr = 1'b0;
		uvr = 1'b0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_manual();
		t_invalid();
		t_auto();
		t_pause();
		t_volt();
		complete_run();
	end
endmodule // tb
